// >>> src/rtc_top.sv
// Real-time trace capture: trigger modes, trace buffer, counters, AXI regs
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

// Functional notes
// - Go-start fill mode begins storing at the go command.
// - Go-start fill stops after range cycles, idles until break.
// - Event-start fill begins at event match, stores range cycles, stops.
// - The matching event cycle itself is not stored in event-start fill.
// - Halt-stop stores from go until breakpoint or halt switch.
// - Halt-stop, event-stop, event-centered overwrite oldest entry when full.
// - Event-stop records continuously, stops after storing the event cycle.
// - Event-centered starts recording right at the go command.
// - Event-centered records exactly range cycles after the event, then stops.
// - Snapshot mode pauses after each range until the next event.
// - Snapshot mode ignores events once the whole buffer is full.
// - T-state clock counter counts every T-state, readable as status.
// - Stored counts since program start and since last resume.
// - Full status shows once 2045 cycles are stored.
// - Counter-clear command zeroes the T-state clock counter.
// - Status always shows the latest programmed mode and range.
// - Each entry is 32 bits: data, address, bus status.
// - Halt-stop and event-stop ignore range, use whole buffer.
module rtc_top
(
   // Clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // Emulated processor bus
   input  wire logic               cyc_valid,
   input  wire rtc_pkg::rtc_entry_t bus_cyc,
   input  wire logic               tstate,
   // Emulator control
   input  wire logic               go_start,
   input  wire logic               go_fresh,
   input  wire logic               event_hit,
   input  wire logic               brk_hit,
   input  wire logic               halt_sw,
   // Trace status
   output logic                    storing,
   output logic                    buf_full,
   // AXI4-Lite slave
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready
);

   rtc_pkg::rtc_st_t    q;
   rtc_pkg::rtc_st_t    d;
   rtc_pkg::rtc_entry_t mem [0:rtc_pkg::BUF_DEPTH-1];
   logic                wr;
   logic                counter_clear_cmd;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction

   always_comb
   begin
      logic [31:0] ctrl_w;
      logic [31:0] rd;
      logic        seg_end;
      logic        cap;
      logic [31:0] idx_w;
      ctrl_w  = (32'(q.mode) << rtc_pkg::CTRL_MODE_LSB)
              | (32'(q.range) << rtc_pkg::CTRL_RANGE_LSB);
      rd      = 32'h0000_0000;
      seg_end = ((q.rng_cnt + 11'h001) == q.range);
      cap     = ((q.fill + 12'h001) >= rtc_pkg::BUF_DEPTH);
      idx_w   = 32'h0000_0000;
      d       = q;
      wr      = 1'b0;
      counter_clear_cmd = 1'b0;

      // Trigger sequencing, one decision per machine cycle
      if (cyc_valid)
      begin
         case (q.state)
            rtc_pkg::ST_WAIT:
            begin
               if (event_hit)
               begin
                  d.state   = rtc_pkg::ST_STORE;
                  d.rng_cnt = 11'h000;
               end
            end
            rtc_pkg::ST_STORE, rtc_pkg::ST_POST: wr = 1'b1;
            default: ;
         endcase
      end
      if (wr)
      begin
         d.wptr     = q.wptr + 11'h001;
         d.fill     = cap ? rtc_pkg::BUF_DEPTH : q.fill + 12'h001;
         d.rng_cnt  = q.rng_cnt + 11'h001;
         d.n_start  = q.n_start + 16'h0001;
         d.n_resume = q.n_resume + 16'h0001;
         case (q.mode)
            rtc_pkg::go_start_fill_mode, rtc_pkg::event_start_fill_mode:
            begin
               if (seg_end || cap)
                  d.state = rtc_pkg::ST_DONE;
            end
            rtc_pkg::event_stop_mode:
            begin
               // Range plays no part here
               if (event_hit)
                  d.state = rtc_pkg::ST_DONE;
            end
            rtc_pkg::event_centered_mode:
            begin
               if (q.state == rtc_pkg::ST_STORE && event_hit)
               begin
                  d.state   = rtc_pkg::ST_POST;
                  d.rng_cnt = 11'h000;
               end
               else if (q.state == rtc_pkg::ST_POST && seg_end)
                  d.state = rtc_pkg::ST_DONE;
            end
            rtc_pkg::event_snapshot_repeat_mode:
            begin
               if (cap)
                  d.state = rtc_pkg::ST_DONE;
               else if (seg_end)
                  d.state = rtc_pkg::ST_WAIT;
            end
            default: ;
         endcase
      end

      // A break ends emulation and with it any storing
      if ((brk_hit || halt_sw) && q.state != rtc_pkg::ST_IDLE)
         d.state = rtc_pkg::ST_DONE;

      // Go re-arms; a fresh start also clears the since-start count
      if (go_start)
      begin
         d.wptr     = 11'h000;
         d.fill     = 12'h000;
         d.rng_cnt  = 11'h000;
         d.n_resume = 16'h0000;
         if (go_fresh)
            d.n_start = 16'h0000;
         if (q.mode == rtc_pkg::event_start_fill_mode ||
             q.mode == rtc_pkg::event_snapshot_repeat_mode)
            d.state = rtc_pkg::ST_WAIT;
         else
            d.state = rtc_pkg::ST_STORE;
      end

      // AXI write channels, taken in either order
      if (s_axi_awvalid && q.awready)
      begin
         d.aw_got  = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready)
      begin
         d.w_got  = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.aw_got && q.w_got && !q.bvalid)
      begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = rtc_pkg::RESP_OKAY;
         case (q.aw_addr)
            rtc_pkg::OFS_CTRL:
            begin
               ctrl_w  = merge(ctrl_w, q.w_data, q.w_strb);
               d.mode  = rtc_pkg::rtc_mode_t'(
                  ctrl_w[rtc_pkg::CTRL_MODE_LSB +: 3]);
               d.range = ctrl_w[rtc_pkg::CTRL_RANGE_LSB +: 11];
            end
            rtc_pkg::OFS_CMD:
               counter_clear_cmd = q.w_strb[0] &&
                  q.w_data[rtc_pkg::CMD_CLEAR_BIT];
            rtc_pkg::OFS_RIDX:
            begin
               idx_w    = merge({21'h00000, q.rd_idx}, q.w_data, q.w_strb);
               d.rd_idx = idx_w[10:0];
            end
            rtc_pkg::OFS_TCLK, rtc_pkg::OFS_NCYC, rtc_pkg::OFS_STAT,
            rtc_pkg::OFS_RDAT: ;
            default: d.bresp = rtc_pkg::RESP_SLVERR;
         endcase
      end
      if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;

      // T-state counter; clear wins over a count in the same cycle
      if (counter_clear_cmd)
         d.tclk = 32'h0000_0000;
      else if (tstate)
         d.tclk = q.tclk + 32'h0000_0001;

      // AXI read channel
      if (s_axi_arvalid && q.arready)
      begin
         d.rvalid = 1'b1;
         d.rresp  = rtc_pkg::RESP_OKAY;
         case (s_axi_araddr)
            rtc_pkg::OFS_CTRL: rd = ctrl_w;
            rtc_pkg::OFS_TCLK: rd = q.tclk;
            rtc_pkg::OFS_NCYC:
               rd = {16'h0000, q.n_start}
                  | (32'(q.n_resume) << rtc_pkg::NCYC_RES_LSB);
            rtc_pkg::OFS_STAT:
               rd = (32'(q.storing) << rtc_pkg::STAT_STORE_BIT)
                  | (32'(q.full) << rtc_pkg::STAT_FULL_BIT)
                  | (32'(q.state) << rtc_pkg::STAT_STATE_LSB)
                  | (32'(q.wptr) << rtc_pkg::STAT_WPTR_LSB);
            rtc_pkg::OFS_RIDX: rd = {21'h00000, q.rd_idx};
            rtc_pkg::OFS_RDAT: rd = mem[q.rd_idx];
            rtc_pkg::OFS_CMD: ;
            default: d.rresp = rtc_pkg::RESP_SLVERR;
         endcase
         d.rdata = rd;
      end
      if (q.rvalid && s_axi_rready)
         d.rvalid = 1'b0;

      d.storing = (d.state == rtc_pkg::ST_STORE ||
                   d.state == rtc_pkg::ST_POST);
      d.full    = (d.fill >= rtc_pkg::FULL_CNT);
      d.awready = !d.aw_got && !d.bvalid;
      d.wready  = !d.w_got && !d.bvalid;
      d.arready = !d.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q       <= '0;
         q.range <= rtc_pkg::RANGE_RST;
      end
      else
         q <= d;
   end

   // Buffer holds no reset; contents are only meaningful after a capture
   always_ff @(posedge aclk)
   begin
      if (wr)
         mem[q.wptr] <= bus_cyc;
   end

   assign storing       = q.storing;
   assign buf_full      = q.full;
   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_GO_STORE: assert property (
      go_start && q.mode == rtc_pkg::go_start_fill_mode |=> storing)
      else $error("go did not start storing");
   AST_EVT_SKIP: assert property (
      q.state == rtc_pkg::ST_WAIT && cyc_valid && event_hit && !go_start &&
      !brk_hit && !halt_sw
      |=> storing && q.wptr == $past(q.wptr))
      else $error("event cycle was stored");
   AST_FILL_END: assert property (
      wr && q.mode == rtc_pkg::go_start_fill_mode &&
      q.rng_cnt + 11'h001 == q.range && !go_start |=> !storing)
      else $error("fill mode kept storing past range");
   AST_EVT_STOP: assert property (
      wr && q.mode == rtc_pkg::event_stop_mode && event_hit && !go_start
      |=> q.state == rtc_pkg::ST_DONE)
      else $error("event-stop did not stop");
   AST_BRK_STOP: assert property (
      (brk_hit || halt_sw) && storing && !go_start |=> !storing)
      else $error("break did not end storing");
   AST_FULL: assert property (
      wr && q.fill == rtc_pkg::FULL_CNT - 12'h001 && !go_start
      |=> buf_full)
      else $error("full not shown at 2045");
   AST_CNT_CLEAR: assert property (
      counter_clear_cmd |=> q.tclk == 32'h0000_0000)
      else $error("clock counter not cleared");
   AST_TCLK: assert property (
      tstate && !counter_clear_cmd
      |=> q.tclk == $past(q.tclk) + 32'h0000_0001)
      else $error("clock counter missed a T-state");
   AST_WRAP: assert property (
      wr && q.wptr == rtc_pkg::PTR_LAST && !go_start |=> q.wptr == 11'h000)
      else $error("write pointer did not wrap");
   AST_SNAP_IGN: assert property (
      q.state == rtc_pkg::ST_DONE &&
      q.mode == rtc_pkg::event_snapshot_repeat_mode && !go_start
      |=> q.state == rtc_pkg::ST_DONE)
      else $error("snapshot mode re-armed after full");

endmodule // rtc_top

// >>> include/rtc_pkg.sv
// Constants, types and state record of the real-time trace capture block
package rtc_pkg;

   // Buffer geometry and counts
   localparam logic [11:0] BUF_DEPTH = 12'h800;   // 2K entries
   localparam logic [11:0] FULL_CNT  = 12'h7FD;   // 2045 stored cycles
   localparam logic [10:0] RANGE_RST = 11'h7FD;   // 2045
   localparam logic [10:0] PTR_LAST  = 11'h7FF;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD  = 8'h04;
   localparam logic [7:0] OFS_TCLK = 8'h08;
   localparam logic [7:0] OFS_NCYC = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_RIDX = 8'h14;
   localparam logic [7:0] OFS_RDAT = 8'h18;

   // Field positions
   localparam int unsigned CTRL_MODE_LSB  = 0;
   localparam int unsigned CTRL_RANGE_LSB = 16;
   localparam int unsigned CMD_CLEAR_BIT  = 0;
   localparam int unsigned STAT_STORE_BIT = 0;
   localparam int unsigned STAT_FULL_BIT  = 1;
   localparam int unsigned STAT_STATE_LSB = 4;
   localparam int unsigned STAT_WPTR_LSB  = 16;
   localparam int unsigned NCYC_RES_LSB   = 16;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      go_start_fill_mode         = 3'b000,
      halt_stop_mode             = 3'b001,
      event_start_fill_mode      = 3'b010,
      event_centered_mode        = 3'b011,
      event_stop_mode            = 3'b100,
      event_snapshot_repeat_mode = 3'b101
   } rtc_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_WAIT  = 3'b001,
      ST_STORE = 3'b010,
      ST_POST  = 3'b011,
      ST_DONE  = 3'b100
   } rtc_state_t;

   // One machine cycle of the processor bus, also one buffer entry
   typedef struct packed {
      logic [7:0]  stat;
      logic [15:0] addr;
      logic [7:0]  data;
   } rtc_entry_t;

   typedef struct packed {
      rtc_state_t  state;
      rtc_mode_t   mode;
      logic [10:0] range;
      logic [10:0] wptr;
      logic [11:0] fill;
      logic [10:0] rng_cnt;
      logic        storing;
      logic        full;
      logic [31:0] tclk;
      logic [15:0] n_start;
      logic [15:0] n_resume;
      logic [10:0] rd_idx;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } rtc_st_t;

endpackage

// >>> tb/rtc_cpu_model.sv
// Behavioural processor bus and event source for the trace bench
`timescale 1ns/1ps
module rtc_cpu_model
(
   // Clock
   input  wire logic           aclk,
   // Processor bus and event line
   output rtc_pkg::rtc_entry_t bus_cyc,
   output logic                cyc_valid,
   output logic                tstate,
   output logic                event_hit
);
   rtc_pkg::rtc_entry_t q_sent[$];
   int                  n_t = 0;

   initial
   begin
      bus_cyc   = '0;
      cyc_valid = 1'b0;
      tstate    = 1'b0;
      event_hit = 1'b0;
   end

   // Event only rides on a machine cycle; idle bus shows inverted data
   task run(input int n, input int ev, input bit slow);
      rtc_pkg::rtc_entry_t e;
      for (int i = 0; i < n; i++)
      begin
         e = rtc_pkg::rtc_entry_t'($urandom);
         @(posedge aclk);
         bus_cyc   <= e;
         cyc_valid <= 1'b1;
         event_hit <= (i == ev);
         tstate    <= 1'b1;
         n_t++;
         q_sent.push_back(e);
         if (slow)
         begin
            @(posedge aclk);
            bus_cyc   <= ~e;
            cyc_valid <= 1'b0;
            event_hit <= 1'b0;
            n_t++;
         end
      end
      @(posedge aclk);
      bus_cyc <= ~bus_cyc;
      {cyc_valid, event_hit, tstate} <= 3'b000;
   endtask
endmodule // rtc_cpu_model

// >>> tb/tb_top.sv
// Self-checking bench for the real-time trace capture block
`timescale 1ns/1ps
module tb_top;
   logic                aclk    = 1'b0;
   logic                aresetn = 1'b0;
   logic                go_start = 1'b0, go_fresh = 1'b0;
   logic                brk_hit = 1'b0, halt_sw = 1'b0;
   logic                cyc_valid, tstate, event_hit, storing, buf_full;
   rtc_pkg::rtc_entry_t bus_cyc;
   logic [7:0]          awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]         wdata = 32'h0, rdata, rd;
   logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                arvalid = 1'b0, rready = 1'b0;
   logic                awready, wready, bvalid, arready, rvalid;
   logic [1:0]          bresp, rresp, rsp;
   int                  errors = 0, n_checks = 0, r;

   always #5 aclk = ~aclk;

   rtc_cpu_model cpu (.aclk(aclk), .bus_cyc(bus_cyc), .cyc_valid(cyc_valid),
      .tstate(tstate), .event_hit(event_hit));

   rtc_top DUT (.aclk(aclk), .aresetn(aresetn), .cyc_valid(cyc_valid),
      .bus_cyc(bus_cyc), .tstate(tstate), .go_start(go_start),
      .go_fresh(go_fresh), .event_hit(event_hit), .brk_hit(brk_hit),
      .halt_sw(halt_sw), .storing(storing), .buf_full(buf_full),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   task test_done;
      $display("checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask

   task tmo(input int k);
      if (k >= 200)
      begin
         chk("handshake", 32'h0, 32'h1);
         test_done();
      end
   endtask

   task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (k = 0; k < 200; k++)
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      tmo(k);
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask

   task axr(input logic [7:0] a);
      int k;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (k = 0; k < 200; k++)
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd     = rdata;
      rsp    = rresp;
      rready <= 1'b0;
      tmo(k);
   endtask

   task go(input bit fresh);
      @(posedge aclk);
      go_start <= 1'b1;
      go_fresh <= fresh;
      cpu.q_sent.delete();
      @(posedge aclk);
      go_start <= 1'b0;
   endtask

   task brk(input bit sw);
      @(posedge aclk);
      if (sw) halt_sw <= 1'b1;
      else brk_hit <= 1'b1;
      @(posedge aclk);
      {halt_sw, brk_hit} <= 2'b00;
      @(posedge aclk);
      chk("storing after break", {31'h0, storing}, 32'h0);
   endtask

   function automatic int model(int m, int rg, int pre, int ev, int post);
      int t, p;
      t = pre + ev + post;
      p = post < rg ? post : rg;
      case (m)
         0: return t < rg ? t : rg;
         1: return t;
         2, 5: return ev ? p : 0;
         3: return ev ? pre + 1 + p : t;
         default: return ev ? pre + 1 : t;
      endcase
   endfunction

   function automatic bit st(int m, int rg, int pre, int ev, int post);
      case (m)
         0: return pre + ev + post < rg;
         1: return 1'b1;
         2, 5: return ev && post < rg;
         3: return !ev || post < rg;
         default: return !ev;
      endcase
   endfunction

   task scen(input string nm, input int m, rg, pre, ev, post);
      int c, f, s;
      logic [31:0] cw;
      cw = {5'h00, rg[10:0], 13'h0000, m[2:0]};
      axw(rtc_pkg::OFS_CTRL, cw, rtc_pkg::RESP_OKAY);
      axr(rtc_pkg::OFS_CTRL);
      chk("ctrl", rd, cw);
      go(1'b1);
      @(posedge aclk);
      s = int'(m inside {0, 1, 3, 4});
      chk("storing at go", {31'h0, storing}, s);
      cpu.run(pre + ev + post, ev ? pre : -1, 1'($urandom % 2));
      c = model(m, rg, pre, ev, post);
      f = (m == 2 || m == 5) ? pre + 1 : 0;
      repeat (2) @(posedge aclk);
      s = int'(st(m, rg, pre, ev, post));
      chk("storing", {31'h0, storing}, s);
      chk("full", {31'h0, buf_full}, 32'(c >= 2045));
      axr(rtc_pkg::OFS_NCYC);
      chk("count", {16'h0, rd[15:0]}, 32'(c));
      axr(rtc_pkg::OFS_STAT);
      chk("wptr", {21'h0, rd[26:16]}, 32'(c % 2048));
      if (c > 0)
      begin
         axw(rtc_pkg::OFS_RIDX, 32'((c - 1) % 2048), rtc_pkg::RESP_OKAY);
         axr(rtc_pkg::OFS_RDAT);
         chk("entry", rd, cpu.q_sent[f + c - 1]);
      end
      $display("test %s done", nm);
   endtask

   initial
   begin
      #1000000;
      chk("run time", 32'h0, 32'h1);
      test_done();
   end

   initial
   begin
      void'($urandom(20386));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axr(rtc_pkg::OFS_CTRL);
      chk("ctrl reset", rd, {5'h00, rtc_pkg::RANGE_RST, 16'h0000});
      axr(8'h1C);
      chk("unmapped", {rd[29:0], rsp}, {30'h0, rtc_pkg::RESP_SLVERR});
      axw(8'h1C, 32'h0, rtc_pkg::RESP_SLVERR);
      r = 2 + $urandom % 8;
      scen("go fill", 0, r, 0, 0, 20);
      scen("event fill", 2, r, 6, 1, 20);
      scen("halt stop", 1, r, 2100, 0, 0);
      brk(1'b0);
      scen("event stop", 4, r, 30, 1, 5);
      scen("centered", 3, r, 10, 1, 20);
      scen("snapshot", 5, r, 3, 1, 12);
      cpu.run(12, 0, 1'b0);
      axr(rtc_pkg::OFS_NCYC);
      chk("second snapshot", {16'h0, rd[15:0]}, 32'(2 * r));
      scen("snapshot full", 5, 2045, 0, 1, 2050);
      cpu.run(10, 0, 1'b0);
      cpu.run(10, 0, 1'b0);
      axr(rtc_pkg::OFS_NCYC);
      chk("capacity", {16'h0, rd[15:0]}, 32'd2048);
      chk("no restart", {31'h0, storing}, 32'h0);
      scen("halt counts", 1, r, 5, 0, 0);
      brk(1'b1);
      go(1'b0);
      cpu.run(4, -1, 1'b0);
      brk(1'b0);
      axr(rtc_pkg::OFS_NCYC);
      chk("resume counts", rd, {16'd4, 16'd9});
      axw(rtc_pkg::OFS_CMD, 32'h1, rtc_pkg::RESP_OKAY);
      axr(rtc_pkg::OFS_TCLK);
      chk("tclk clear", rd, 32'h0);
      cpu.n_t = 0;
      cpu.run(37, -1, 1'b1);
      repeat (2) @(posedge aclk);
      axr(rtc_pkg::OFS_TCLK);
      chk("tclk", rd, 32'(cpu.n_t));
      $display("test counters done");
      test_done();
   end
endmodule // tb_top
